// ===== pmcm_asserts.sv
// checker for the power-mode and clock manager
`timescale 1ns/1ps
module pmcm_asserts #(
  parameter int unsigned IO_W = 31
) (
  input wire logic            core_clk,      // clock
  input wire logic            srst,          // sync reset
  input wire logic            por_event,     // power-on event
  input wire logic            reset_pin_n,   // reset pin
  input wire logic            cpu_ack,       // processor ack
  input wire logic            irq_any,       // interrupt
  input wire logic            rtc_event,     // timer wake
  input wire logic            sensor_event,  // sensor wake
  input wire logic            ext_wake,      // pin wake
  input wire logic [IO_W-1:0] io_in,         // live io
  input wire logic [IO_W-1:0] shdn_wake_en,  // wake pins
  input wire logic [2:0]      mode,          // power mode
  input wire logic            cpu_clk_en,    // cpu clock
  input wire logic            periph_clk_en, // periph clock
  input wire logic            aon_pwr_en,    // always-on power
  input wire logic            sram_retain,   // sram retention
  input wire logic            sys_reset,     // reset out
  input wire logic            cpu_resume,    // resume pulse
  input wire logic            io_latch,      // io hold
  input wire logic [IO_W-1:0] io_latched,    // held io
  input wire logic            hf_clk_en,     // main clock
  input wire logic            lf_clk_en,     // low clock
  input wire logic [1:0]      lf_src,        // low source
  input wire logic            lf_clk_out_en, // low clock out
  input wire logic [1:0]      reset_cause    // reset cause
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // wake sequences
  sequence s_idle_irq;
    mode == 3'h1 && irq_any && reset_pin_n && !por_event;
  endsequence
  sequence s_stby_ev;
    mode == 3'h2 && (ext_wake || rtc_event || sensor_event)
      && reset_pin_n && !por_event;
  endsequence
  sequence s_shdn_edge;
    mode == 3'h3 && $past(mode) == 3'h3 && reset_pin_n && !por_event
      && |(shdn_wake_en & (io_in ^ $past(io_in)));
  endsequence
  // ==========================================================
  // properties
  property p_idle; mode == 3'h1 |-> !cpu_clk_en && periph_clk_en; endproperty
  property p_idle_wake; s_idle_irq |=> mode == 3'h0; endproperty
  property p_stby;
    mode == 3'h2 |-> aon_pwr_en && !periph_clk_en && io_latch
      && sram_retain && !hf_clk_en && lf_clk_en;
  endproperty
  property p_stby_wake; s_stby_ev |=> mode == 3'h0 && cpu_resume; endproperty
  property p_shdn;
    mode == 3'h3 |-> !aon_pwr_en && io_latch && !lf_clk_en && !hf_clk_en;
  endproperty
  property p_hold; io_latch && $past(io_latch) |-> $stable(io_latched);
  endproperty
  property p_shdn_wake;
    s_shdn_edge |=> sys_reset && reset_cause == pmcm_pkg::CAUSE_SHDN_PIN;
  endproperty
  property p_pin;
    !reset_pin_n && !por_event |=> mode == 3'h4
      && reset_cause == pmcm_pkg::CAUSE_PIN;
  endproperty
  property p_lf_out; lf_clk_out_en |-> lf_src != 2'h2 && lf_clk_en;
  endproperty
  property p_ack;
    mode == 3'h0 && !cpu_ack && reset_pin_n && !por_event |=> mode == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle clocks");
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake");
  a_stby: assert property (p_stby) else $error("standby");
  a_stby_wake: assert property (p_stby_wake) else $error("stby wake");
  a_shdn: assert property (p_shdn) else $error("shutdown");
  a_hold: assert property (p_hold) else $error("io hold");
  a_shdn_wake: assert property (p_shdn_wake) else $error("shdn wake");
  a_pin: assert property (p_pin) else $error("reset pin");
  a_lf_out: assert property (p_lf_out) else $error("lf out");
  a_ack: assert property (p_ack) else $error("no ack");
endmodule

bind pmcm_power_mode_clock_manager pmcm_asserts #(.IO_W(IO_W))
  u_pmcm_asserts (.*);

// ===== pmcm_pkg.sv
// package of modes, clock sources and reset causes for the power manager
package pmcm_pkg;
  // ==========================================================
  // power modes
  typedef enum logic [2:0] {
    PMCM_ACTIVE,
    PMCM_IDLE,
    PMCM_STANDBY,
    PMCM_SHUTDOWN,
    PMCM_RESET_HELD
  } pmcm_mode_e;

  // ==========================================================
  // mode request codes
  localparam logic [1:0] REQ_IDLE     = 2'h1;
  localparam logic [1:0] REQ_STANDBY  = 2'h2;
  localparam logic [1:0] REQ_SHUTDOWN = 2'h3;

  // ==========================================================
  // low-frequency clock source select
  localparam logic [1:0] LF_SRC_RC   = 2'h0;
  localparam logic [1:0] LF_SRC_XTAL = 2'h1;
  localparam logic [1:0] LF_SRC_EXT  = 2'h2;

  // ==========================================================
  // reset cause encoding
  localparam logic [1:0] CAUSE_POR      = 2'h0;
  localparam logic [1:0] CAUSE_PIN      = 2'h1;
  localparam logic [1:0] CAUSE_SHDN_PIN = 2'h2;

  // ==========================================================
  // reset pulse length and io width
  localparam int unsigned RST_PULSE_CYC = 4;
  localparam int unsigned IO_WIDTH      = 31;
endpackage

// ===== pmcm_power_mode_clock_manager.sv
// power-mode and system-clock manager core
`timescale 1ns/1ps
module pmcm_power_mode_clock_manager #(
  parameter int unsigned IO_W = pmcm_pkg::IO_WIDTH
) (
  input  wire logic            core_clk,        // 100 MHz clock
  input  wire logic            srst,            // sync reset, active high
  input  wire logic            por_event,       // power-on reset pulse
  input  wire logic            reset_pin_n,     // reset pin, low = held
  input  wire logic [1:0]      mode_req,        // sw mode request code
  input  wire logic            mode_req_valid,  // request strobe
  input  wire logic            cpu_ack,         // processor acknowledge
  input  wire logic            irq_any,         // any pending interrupt
  input  wire logic            rtc_event,       // timer wake event
  input  wire logic            sensor_event,    // sensor processor event
  input  wire logic            ext_wake,        // external pin wake
  input  wire logic [IO_W-1:0] io_in,           // live io values
  input  wire logic [IO_W-1:0] shdn_wake_en,    // shutdown wake pins
  input  wire logic            mf_in_standby,   // keep medium clk standby
  input  wire logic            hf_sel_xtal,     // main clk from crystal
  input  wire logic [1:0]      lf_sel,          // low clk source select
  input  wire logic            lf_out_en,       // request low clk out
  input  wire logic            radio_req,       // radio enable request
  input  wire logic            vdd_low,         // supply below window
  input  wire logic            vdd_high,        // supply above window
  input  wire logic            temp_low,        // temp below window
  input  wire logic            temp_high,       // temp above window
  input  wire logic            mon_wake_en,     // monitor may wake
  output logic [2:0]           mode,            // current power mode
  output logic                 cpu_clk_en,      // cpu core clock enable
  output logic                 mem_clk_en,      // cpu memory clock enable
  output logic                 periph_clk_en,   // peripheral clock enable
  output logic                 periph_pwr_en,   // peripheral power enable
  output logic                 aon_pwr_en,      // always-on domain power
  output logic                 sensor_pwr_en,   // sensor processor power
  output logic                 sram_retain,     // sram retention mode
  output logic                 sram_pwr_en,     // sram power
  output logic                 reg_retain,      // partial reg retention
  output logic                 sys_reset,       // system reset pulse
  output logic                 cpu_resume,      // resume-in-place pulse
  output logic                 io_latch,        // io latch hold
  output logic [IO_W-1:0]      io_latched,      // held io values
  output logic                 hf_clk_en,       // main clock enable
  output logic                 hf_src_xtal,     // main clock from crystal
  output logic                 mf_clk_en,       // medium clock enable
  output logic                 lf_clk_en,       // low clock enable
  output logic [1:0]           lf_src,          // low clock source
  output logic                 lf_clk_out_en,   // drive low clk to pin
  output logic                 radio_en,        // radio allowed
  output logic                 mon_irq,         // monitor interrupt
  output logic [1:0]           reset_cause      // last reset cause
);

  // ==========================================================
  // state
  pmcm_pkg::pmcm_mode_e state;
  pmcm_pkg::pmcm_mode_e next_state;
  logic [1:0]           pend_req;
  logic                 pend_valid;
  logic [IO_W-1:0]      io_prev;
  logic [2:0]           rst_cnt;
  logic                 mon_evt;
  logic                 shdn_pin_wake;
  logic                 pin_held;

  assign mon_evt       = vdd_low | vdd_high | temp_low | temp_high;
  assign shdn_pin_wake = |((io_in ^ io_prev) & shdn_wake_en);
  assign pin_held      = ~reset_pin_n;

  // ==========================================================
  // request capture
  // request waits ack
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pend_valid <= 1'b0;
      pend_req   <= 2'h0;
    end else if (mode_req_valid && state == pmcm_pkg::PMCM_ACTIVE) begin
      pend_valid <= 1'b1;
      pend_req   <= mode_req;
    end else if (pend_valid && cpu_ack) begin
      pend_valid <= 1'b0;
    end
  end

  // ==========================================================
  // mode sequencing
  always_comb begin
    next_state = state;
    case (state)
      pmcm_pkg::PMCM_ACTIVE: begin
        if (pend_valid && cpu_ack) begin
          case (pend_req)
            pmcm_pkg::REQ_IDLE:     next_state = pmcm_pkg::PMCM_IDLE;
            pmcm_pkg::REQ_STANDBY:  next_state = pmcm_pkg::PMCM_STANDBY;
            pmcm_pkg::REQ_SHUTDOWN: next_state = pmcm_pkg::PMCM_SHUTDOWN;
            default:                next_state = pmcm_pkg::PMCM_ACTIVE;
          endcase
        end
      end
      pmcm_pkg::PMCM_IDLE: begin
        if (irq_any) begin
          next_state = pmcm_pkg::PMCM_ACTIVE;
        end
      end
      pmcm_pkg::PMCM_STANDBY: begin
        if (ext_wake || rtc_event || sensor_event ||
            (mon_wake_en && mon_evt)) begin
          next_state = pmcm_pkg::PMCM_ACTIVE;
        end
      end
      pmcm_pkg::PMCM_SHUTDOWN: begin
        if (shdn_pin_wake) begin
          next_state = pmcm_pkg::PMCM_RESET_HELD;
        end
      end
      pmcm_pkg::PMCM_RESET_HELD: begin
        if (reset_pin_n && rst_cnt == 3'h0) begin
          next_state = pmcm_pkg::PMCM_ACTIVE;
        end
      end
      default: next_state = pmcm_pkg::PMCM_RESET_HELD;
    endcase
    if (pin_held || por_event) begin
      next_state = pmcm_pkg::PMCM_RESET_HELD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= pmcm_pkg::PMCM_RESET_HELD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode <= 3'h4;
    end else begin
      mode <= 3'(next_state);
    end
  end

  // ==========================================================
  // reset pulse and cause
  // reset cause record
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reset_cause <= pmcm_pkg::CAUSE_POR;
    end else if (por_event) begin
      reset_cause <= pmcm_pkg::CAUSE_POR;
    end else if (pin_held) begin
      reset_cause <= pmcm_pkg::CAUSE_PIN;
    end else if (state == pmcm_pkg::PMCM_SHUTDOWN && shdn_pin_wake) begin
      reset_cause <= pmcm_pkg::CAUSE_SHDN_PIN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_cnt   <= 3'(pmcm_pkg::RST_PULSE_CYC);
      sys_reset <= 1'b1;
    end else if (next_state == pmcm_pkg::PMCM_RESET_HELD &&
                 state != pmcm_pkg::PMCM_RESET_HELD) begin
      rst_cnt   <= 3'(pmcm_pkg::RST_PULSE_CYC);
      sys_reset <= 1'b1;
    end else if (state == pmcm_pkg::PMCM_RESET_HELD) begin
      if (rst_cnt != 3'h0) begin
        rst_cnt <= rst_cnt - 3'h1;
      end
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_resume <= 1'b0;
    end else begin
      cpu_resume <= (state == pmcm_pkg::PMCM_STANDBY) &&
                    (next_state == pmcm_pkg::PMCM_ACTIVE);
    end
  end

  // ==========================================================
  // io latch
  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_prev <= '0;
    end else begin
      io_prev <= io_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_latch   <= 1'b0;
      io_latched <= '0;
    end else if (next_state == pmcm_pkg::PMCM_STANDBY ||
                 next_state == pmcm_pkg::PMCM_SHUTDOWN) begin
      io_latch <= 1'b1;
      if (!io_latch) begin
        io_latched <= io_in;
      end
    end else begin
      io_latch   <= (state == pmcm_pkg::PMCM_SHUTDOWN) && pin_held;
      io_latched <= io_latch ? io_latched : io_in;
    end
  end

  // ==========================================================
  // domain power and clocks
  // per-mode clock, power and retention enables
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_clk_en    <= 1'b0;
      mem_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
      periph_pwr_en <= 1'b0;
      aon_pwr_en    <= 1'b0;
      sensor_pwr_en <= 1'b0;
      sram_pwr_en   <= 1'b0;
      sram_retain   <= 1'b0;
      reg_retain    <= 1'b0;
    end else begin
      cpu_clk_en    <= next_state == pmcm_pkg::PMCM_ACTIVE;
      mem_clk_en    <= next_state == pmcm_pkg::PMCM_ACTIVE;
      periph_clk_en <= next_state == pmcm_pkg::PMCM_ACTIVE ||
                       next_state == pmcm_pkg::PMCM_IDLE;
      periph_pwr_en <= next_state == pmcm_pkg::PMCM_ACTIVE ||
                       next_state == pmcm_pkg::PMCM_IDLE;
      aon_pwr_en    <= next_state != pmcm_pkg::PMCM_SHUTDOWN &&
                       next_state != pmcm_pkg::PMCM_RESET_HELD;
      sensor_pwr_en <= next_state != pmcm_pkg::PMCM_SHUTDOWN &&
                       next_state != pmcm_pkg::PMCM_RESET_HELD;
      sram_pwr_en   <= next_state != pmcm_pkg::PMCM_SHUTDOWN &&
                       next_state != pmcm_pkg::PMCM_RESET_HELD;
      sram_retain   <= next_state == pmcm_pkg::PMCM_STANDBY;
      reg_retain    <= next_state == pmcm_pkg::PMCM_STANDBY;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hf_clk_en <= 1'b0;
      mf_clk_en <= 1'b0;
      lf_clk_en <= 1'b0;
    end else begin
      hf_clk_en <= next_state == pmcm_pkg::PMCM_ACTIVE ||
                   next_state == pmcm_pkg::PMCM_IDLE;
      mf_clk_en <= next_state == pmcm_pkg::PMCM_ACTIVE ||
                   next_state == pmcm_pkg::PMCM_IDLE ||
                   (next_state == pmcm_pkg::PMCM_STANDBY && mf_in_standby);
      lf_clk_en <= next_state == pmcm_pkg::PMCM_ACTIVE ||
                   next_state == pmcm_pkg::PMCM_IDLE ||
                   next_state == pmcm_pkg::PMCM_STANDBY;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hf_src_xtal   <= 1'b0;
      lf_src        <= pmcm_pkg::LF_SRC_RC;
      lf_clk_out_en <= 1'b0;
      radio_en      <= 1'b0;
    end else begin
      hf_src_xtal   <= hf_sel_xtal;
      lf_src        <= (lf_sel == pmcm_pkg::LF_SRC_XTAL ||
                        lf_sel == pmcm_pkg::LF_SRC_EXT) ?
                       lf_sel : pmcm_pkg::LF_SRC_RC;
      lf_clk_out_en <= lf_out_en && lf_sel != pmcm_pkg::LF_SRC_EXT &&
                       (next_state == pmcm_pkg::PMCM_ACTIVE ||
                        next_state == pmcm_pkg::PMCM_IDLE ||
                        next_state == pmcm_pkg::PMCM_STANDBY);
      radio_en      <= radio_req && hf_sel_xtal &&
                       (next_state == pmcm_pkg::PMCM_ACTIVE ||
                        next_state == pmcm_pkg::PMCM_IDLE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mon_irq <= 1'b0;
    end else begin
      mon_irq <= mon_evt && (state == pmcm_pkg::PMCM_ACTIVE ||
                             state == pmcm_pkg::PMCM_IDLE ||
                             state == pmcm_pkg::PMCM_STANDBY);
    end
  end

endmodule

// ===== pmcm_wake_src.sv
// model of pin, timer and sensor wake sources
`timescale 1ns/1ps
module pmcm_wake_src (
  input  wire logic       core_clk,    // clock
  input  wire logic       srst,        // sync reset
  input  wire logic       go,          // start one event
  input  wire logic [1:0] kind,        // 1 pin 2 timer 3 sensor
  input  wire logic [3:0] dly,         // wait cycles
  output logic            ext_wake,    // pin wake
  output logic            rtc_event,   // timer wake
  output logic            sensor_event // sensor wake
);
  logic [3:0] cnt;
  logic [1:0] k;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt <= 4'h0;
    end else if (go) begin
      k   <= kind;
      cnt <= dly + 4'h1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign ext_wake     = cnt == 4'h1 && k == 2'h1;
  assign rtc_event    = cnt == 4'h1 && k == 2'h2;
  assign sensor_event = cnt == 4'h1 && k == 2'h3;
endmodule

// ===== tb.sv
// testbench for the power-mode and clock manager
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, srst = 1'b1, por_event = 1'b0, reset_pin_n = 1'b1;
  logic [1:0] mode_req = 2'h0, lf_sel = 2'h0, kind = 2'h0;
  logic mode_req_valid = 1'b0, cpu_ack = 1'b0, irq_any = 1'b0, go = 1'b0;
  logic mf_in_standby = 1'b0, hf_sel_xtal = 1'b1, lf_out_en = 1'b0;
  logic radio_req = 1'b0, mon_wake_en = 1'b0;
  logic vdd_low = 1'b0, vdd_high = 1'b0, temp_low = 1'b0, temp_high = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [30:0] io_in = 31'h2AAA5555, shdn_wake_en = 31'h00000001, v;
  logic ext_wake, rtc_event, sensor_event, cpu_clk_en, mem_clk_en;
  logic periph_clk_en, periph_pwr_en, aon_pwr_en, sensor_pwr_en, sram_retain;
  logic sram_pwr_en, reg_retain, sys_reset, cpu_resume, io_latch, hf_clk_en;
  logic hf_src_xtal, mf_clk_en, lf_clk_en, lf_clk_out_en, radio_en, mon_irq;
  logic [2:0] mode;
  logic [1:0] lf_src, reset_cause;
  logic [30:0] io_latched;
  int err_count = 0, tests_run = 0;
  wire [7:0] ens = {cpu_clk_en, periph_clk_en, aon_pwr_en, sram_retain,
                    io_latch, hf_clk_en, lf_clk_en, mf_clk_en};
  wire [4:0] ens2 = {mem_clk_en, periph_pwr_en, sensor_pwr_en, sram_pwr_en,
                     reg_retain};
  // rows: request, wake (1-3 partner, 4 irq, 5 io pin), mode, enables
  logic [1:0] rq [6] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h0};
  logic [2:0] wk [6] = '{3'h4, 3'h1, 3'h2, 3'h3, 3'h5, 3'h0};
  logic [2:0] em [6] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h0};
  logic [7:0] en [6] = '{8'h67, 8'h3A, 8'h3A, 8'h3A, 8'h08, 8'hE7};

  pmcm_power_mode_clock_manager u_pmcm_power_mode_clock_manager (.*);
  pmcm_wake_src u_pmcm_wake_src (.*);

  always #5 core_clk = ~core_clk;

  task automatic cmp(input string n, input logic [30:0] e,
                     input logic [30:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic req(input logic [1:0] c);
    @(posedge core_clk);
    mode_req <= c;
    mode_req_valid <= 1'b1;
    @(posedge core_clk);
    mode_req_valid <= 1'b0;
    cpu_ack <= 1'b1;
    @(posedge core_clk);
    cpu_ack <= 1'b0;
    #1;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int k = 0; k < 40; k++) begin
      if (mode === m) break;
      step(1);
    end
  endtask
  task automatic test_done();
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    test_done();
  end

  initial begin
    step(3);
    cmp("rst mode", 31'h4, 31'(mode));
    cmp("rst cause", 31'(pmcm_pkg::CAUSE_POR), 31'(reset_cause));
    @(posedge core_clk);
    srst <= 1'b0;
    step(2);
    cmp("held mode", 31'h4, 31'(mode));
    wait_mode(3'h0);
    for (int i = 0; i < 6; i++) begin
      v = io_in;
      req(rq[i]);
      cmp("mode", 31'(em[i]), 31'(mode));
      cmp("enables", 31'(en[i]), 31'(ens));
      cmp("domains", 31'({en[i][7], en[i][6], en[i][5], en[i][5],
                          en[i][4]}), 31'(ens2));
      @(posedge core_clk);
      io_in <= io_in ^ 31'h00000020;
      step(2);
      cmp("latched", (em[i] >= 3'h2) ? v : io_in, io_latched);
      @(posedge core_clk);
      case (wk[i])
        3'h4: irq_any <= 1'b1;
        3'h5: io_in <= io_in ^ 31'h00000001;
        default: begin
          go <= wk[i] != 3'h0;
          kind <= wk[i][1:0];
          dly <= 4'(i * 3);
        end
      endcase
      @(posedge core_clk);
      go <= 1'b0;
      irq_any <= 1'b0;
      #1;
      if (wk[i] == 3'h5)
        cmp("cause", 31'(pmcm_pkg::CAUSE_SHDN_PIN), 31'(reset_cause));
      wait_mode(3'h0);
      cmp("resume", 31'(wk[i] inside {3'h1, 3'h2, 3'h3}), 31'(cpu_resume));
      cmp("active", 31'h0, 31'(mode));
    end
    @(posedge core_clk);
    mf_in_standby <= 1'b1;
    req(pmcm_pkg::REQ_STANDBY);
    cmp("mf standby", 31'h1, 31'(mf_clk_en));
    req(pmcm_pkg::REQ_IDLE);
    cmp("refused", 31'h2, 31'(mode));
    @(posedge core_clk);
    reset_pin_n <= 1'b0;
    step(2);
    cmp("pin mode", 31'h4, 31'(mode));
    cmp("pin cause", 31'(pmcm_pkg::CAUSE_PIN), 31'(reset_cause));
    cmp("pin reset", 31'h1, 31'(sys_reset));
    @(posedge core_clk);
    reset_pin_n <= 1'b1;
    wait_mode(3'h0);
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      lf_sel <= 2'(s);
      lf_out_en <= 1'b1;
      radio_req <= 1'b1;
      hf_sel_xtal <= s[0];
      {vdd_low, vdd_high, temp_low, temp_high} <= 4'h1 << s;
      step(3);
      cmp("lf src", 31'((s < 3) ? s : 0), 31'(lf_src));
      cmp("lf out", 31'(s != 2), 31'(lf_clk_out_en));
      cmp("radio", 31'(s[0]), 31'(radio_en));
      cmp("hf src", 31'(s[0]), 31'(hf_src_xtal));
      cmp("mon irq", 31'h1, 31'(mon_irq));
    end
    @(posedge core_clk);
    {vdd_low, vdd_high, temp_low, temp_high} <= 4'h0;
    mon_wake_en <= 1'b1;
    req(pmcm_pkg::REQ_STANDBY);
    cmp("mon stby", 31'h2, 31'(mode));
    @(posedge core_clk);
    temp_high <= 1'b1;
    step(1);
    cmp("mon wake", 31'h0, 31'(mode));
    cmp("mon resume", 31'h1, 31'(cpu_resume));
    @(posedge core_clk);
    temp_high <= 1'b0;
    srst <= 1'b1;
    step(2);
    cmp("srst mode", 31'h4, 31'(mode));
    cmp("srst cause", 31'(pmcm_pkg::CAUSE_POR), 31'(reset_cause));
    cmp("mon clear", 31'h0, 31'(mon_irq));
    test_done();
  end
endmodule
